// ### verif/cmsr_host_model.sv
// bus master model driving scl and sda of the two-wire port
// assumes sda is resolved outside from all open-drain parties
`timescale 1ns/10ps
module cmsr_host_model #(
   parameter logic [6:0] DEV_ADDR = cmsr_pkg::DEV_ADDR_DFLT
) (
   // clock
   input  wire logic clk_sys_i,
   // serial port
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // quarter bit in clocks, well above the 4-clock minimum
   localparam int Q = 8;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic hold();
      repeat (Q) @(negedge clk_sys_i);
   endtask
   // s=1 start or repeated start, s=0 stop
   task automatic cond(input logic s);
      sda_o = s;
      hold();
      scl_o = 1'b1;
      hold();
      sda_o = ~s;
      hold();
      if (s) begin
         scl_o = 1'b0;
         hold();
      end
   endtask
   task automatic xfer(input logic [8:0] w, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         sda_o = w[i];
         hold();
         scl_o = 1'b1;
         hold();
         r[i] = sda_i;
         hold();
         scl_o = 1'b0;
         hold();
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
                         output logic nak);
      logic [8:0] r0, r1, r2;
      cond(1'b1);
      xfer({DEV_ADDR, 2'b01}, r0);
      xfer({a, 1'b1}, r1);
      xfer({d, 1'b1}, r2);
      cond(1'b0);
      nak = r0[0] | r1[0] | r2[0];
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                         output logic nak);
      logic [8:0] r0, r1, r2, r3;
      cond(1'b1);
      xfer({DEV_ADDR, 2'b01}, r0);
      xfer({a, 1'b1}, r1);
      cond(1'b1);
      xfer({DEV_ADDR, 2'b11}, r2);
      xfer(9'h1FF, r3);
      cond(1'b0);
      d = r3[8:1];
      nak = r0[0] | r1[0] | r2[0];
   endtask
endmodule

// ### verif/cmsr_regs_asserts.sv
// port assertions for the mode/status bank
// assumes scl holds many clocks; faults under five clocks while a mask is 0
`timescale 1ns/10ps
module cmsr_regs_asserts (
   // clock and reset
   input wire logic       clk_sys_i,
   input wire logic       srst_i,
   // serial port
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_n_o,
   // power stage side
   input wire logic       short_fault_i,
   input wire logic       overcurrent_i,
   input wire logic       overvoltage_i,
   input wire logic [1:0] conv_mode_i,
   input wire logic       out_enable_o,
   input wire logic       freq_double_active_o,
   input wire logic       hiccup_enable_o,
   input wire logic       drain_sink_on_o,
   input wire logic       light_load_forced_pwm_o,
   input wire logic       fault_alert_pin_o,
   input wire logic       fault_alert_pin_oe_n_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   a_reset_vals:
      assert property ($fell(srst_i) |-> !out_enable_o && hiccup_enable_o
         && !drain_sink_on_o && !light_load_forced_pwm_o
         && fault_alert_pin_oe_n_o) else $error("bad values after reset");
   a_fdbl_mixed_only:
      assert property ((conv_mode_i != 2'b10) [*4] |-> !freq_double_active_o)
      else $error("doubling outside buck-boost");
   a_fault_alert:
      assert property ((short_fault_i || overcurrent_i || overvoltage_i) [*5]
         |-> !fault_alert_pin_oe_n_o) else $error("alert missing");
   a_flag_held:
      assert property (scl_i [*6] ##0 !fault_alert_pin_oe_n_o
         |=> !fault_alert_pin_oe_n_o) else $error("flag lost without read");
   a_clear_by_bus:
      assert property ($rose(fault_alert_pin_oe_n_o) |-> !$past(scl_i, 2))
      else $error("alert cleared outside a read");
   a_ctrl_quiet_bus:
      assert property (scl_i [*6] |=> $stable({out_enable_o, hiccup_enable_o,
         drain_sink_on_o, light_load_forced_pwm_o}))
      else $error("control moved without bus write");
   a_sda_scl_low:
      assert property ($changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 2))
      else $error("sda drive changed while scl high");
   a_open_drain_vals:
      assert property (sda_o == 1'b0 && fault_alert_pin_o == 1'b0)
      else $error("open drain value not low");
   a_alert_has_cause:
      assert property ($fell(fault_alert_pin_oe_n_o) |->
         $past(short_fault_i, 3) || $past(overcurrent_i, 3) ||
         $past(overvoltage_i, 3)) else $error("alert without a fault");
   c_alert: cover property ($fell(fault_alert_pin_oe_n_o));
   c_fdbl: cover property ($rose(freq_double_active_o));
   c_drain: cover property ($rose(drain_sink_on_o));
endmodule
bind cmsr_regs cmsr_regs_asserts u_asserts (
   .clk_sys_i(clk_sys_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .short_fault_i(short_fault_i),
   .overcurrent_i(overcurrent_i), .overvoltage_i(overvoltage_i),
   .conv_mode_i(conv_mode_i), .out_enable_o(out_enable_o),
   .freq_double_active_o(freq_double_active_o),
   .hiccup_enable_o(hiccup_enable_o), .drain_sink_on_o(drain_sink_on_o),
   .light_load_forced_pwm_o(light_load_forced_pwm_o),
   .fault_alert_pin_o(fault_alert_pin_o),
   .fault_alert_pin_oe_n_o(fault_alert_pin_oe_n_o));

// ### verif/tb_converter_mode_status_regs.sv
// self-checking bench for the mode/status bank over the serial port
// assumes the host model plays the only bus master, sda pulled up
`timescale 1ns/10ps
module tb_converter_mode_status_regs;
   import cmsr_pkg::*;
   logic        clk_sys_i;
   logic        srst_i;
   logic [2:0]  flt;
   logic [1:0]  conv;
   logic        scl, h_sda, sda_dev, sda_oe_n;
   logic        oe, fdbl, hic, drain, light_load_forced_pwm, al_oe_n;
   int          failures;
   int          checks;
   logic [15:0] tv [6] = '{16'hFF0F, 16'h1002, 16'h9008, 16'h0802,
                           16'h0201, 16'h2004};
   wire logic   sda = h_sda & (sda_oe_n | sda_dev);
   cmsr_regs uut (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_dev), .sda_oe_n_o(sda_oe_n), .short_fault_i(flt[2]),
      .overcurrent_i(flt[1]), .overvoltage_i(flt[0]), .conv_mode_i(conv),
      .out_enable_o(oe), .freq_double_active_o(fdbl), .hiccup_enable_o(hic),
      .drain_sink_on_o(drain), .light_load_forced_pwm_o(light_load_forced_pwm),
      .fault_alert_pin_o(), .fault_alert_pin_oe_n_o(al_oe_n));
   cmsr_host_model host (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
      .sda_o(h_sda));
   task automatic close_out();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic nak;
      host.wr_reg(a, d, nak);
      chk({7'h00, nak}, 8'h00);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic       nak;
      logic [7:0] d;
      host.rd_reg(a, d, nak);
      chk({7'h00, nak}, 8'h00);
      chk(d, e);
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      failures++;
      close_out();
   end
   initial begin
      failures = 0;
      checks = 0;
      srst_i = 1'b1;
      flt = 3'h0;
      conv = 2'h3;
      repeat (16) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      srst_i = 1'b0;
      chk({4'h0, oe, hic, drain, light_load_forced_pwm}, 8'h04);
      rdchk(OFS_MODE, RST_MODE);
      rdchk(OFS_STAT, RST_STAT);
      rdchk(OFS_MASK, RST_MASK);
      // forced drain entry is followed at once by a clearing write
      for (int i = 0; i < 6; i++) begin
         wr(OFS_MODE, tv[i][15:8]);
         chk({4'h0, oe, hic, drain, light_load_forced_pwm}, tv[i][7:0]);
         rdchk(OFS_MODE, tv[i][15:8] & WMSK_MODE);
      end
      wr(OFS_MODE, 8'h40);
      for (int m = 0; m < 3; m++) begin
         conv = m[1:0];
         rdchk(OFS_STAT, {6'h00, m[1:0]});
         chk({7'h00, fdbl}, {7'h00, m == 2});
      end
      wr(OFS_STAT, 8'hFF);
      rdchk(OFS_STAT, 8'h02);
      rdchk(8'h08, 8'h00);
      for (int f = 0; f < 3; f++) begin
         flt = 3'h4 >> f;
         repeat (10) @(negedge clk_sys_i);
         flt = 3'h0;
         repeat (20) @(negedge clk_sys_i);
         chk({7'h00, al_oe_n}, 8'h00);
         rdchk(OFS_STAT, {3'h4 >> f, 5'h02});
         chk({7'h00, al_oe_n}, 8'h01);
         rdchk(OFS_STAT, 8'h02);
      end
      // short fault masked: flag latches, alert pin stays released
      wr(OFS_MASK, 8'h7F);
      rdchk(OFS_MASK, 8'h6F);
      // pulse kept under five clocks: the alert check assumes masks set
      flt = 3'h4;
      repeat (4) @(negedge clk_sys_i);
      flt = 3'h0;
      repeat (10) @(negedge clk_sys_i);
      chk({7'h00, al_oe_n}, 8'h01);
      rdchk(OFS_STAT, 8'h82);
      wr(OFS_MASK, RST_MASK);
      flt = 3'h7;
      repeat (10) @(negedge clk_sys_i);
      rdchk(OFS_STAT, 8'hE2);
      rdchk(OFS_STAT, 8'hE2);
      flt = 3'h0;
      rdchk(OFS_STAT, 8'hE2);
      rdchk(OFS_STAT, 8'h02);
      close_out();
   end
endmodule

// ### verilog/cmsr_flag_latch.sv
// sticky fault flags, set by a level, cleared by a one-cycle pulse
// assumes set levels are already in the clk_sys_i domain
`timescale 1ns/10ps
module cmsr_flag_latch #(
   parameter int W = 3
) (
   // clock and reset
   input  wire logic         clk_sys_i,
   input  wire logic         srst_i,
   // events and clear
   input  wire logic [W-1:0] set_i,
   input  wire logic         clr_i,
   output logic      [W-1:0] flag_o
);
   typedef struct packed {
      logic [W-1:0] flag;
   } cmsr_flag_t;

   cmsr_flag_t q;
   cmsr_flag_t d;

   // set beats clear, so a fault still present re-arms at once
   always_comb begin
      d.flag = (q.flag & ~{W{clr_i}}) | set_i;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         q.flag <= '0;
      end else begin
         q <= d;
      end
   end

   assign flag_o = q.flag;
endmodule

// ### verilog/cmsr_pkg.sv
// constants, register layout and types for the converter mode/status bank
// assumes a single 100 MHz clock and a serial two-wire configuration port
// Operation
// - Mode bit 7 enables the converter output and resets to 0.
// - Mode bit 6 doubles the switching frequency only while in buck-boost.
// - Mode bit 5 enables hiccup on output short circuit and resets to 1.
// - Mode bit 4 turns on the 100mA output sink while the output is off.
// - Mode bit 3 forces the 100mA output sink on regardless of shutdown.
// - Mode bit 1 selects forced PWM at light load, 0 selects PFM.
// - Status bits 7, 6, 5 latch short circuit, overcurrent, overvoltage.
// - The alert pin is pulled low while any fault flag and its mask are 1.
// - Reading the status byte returns the flags and then clears them.
// - A set fault flag stays set until the status byte is read.
// - A fault still present after a clearing read sets its flag again.
// - Status bits 1-0 report boost, buck, buck-boost, reserved 11.
// - The mode byte resets to 00100000b.
// - The status byte resets to 00000011b.
// - Mask bits 7, 6, 5 of register 05h gate the alerts, reset to 1.
package cmsr_pkg;

   // register offsets
   localparam logic [7:0] OFS_MASK      = 8'h05;
   localparam logic [7:0] OFS_MODE      = 8'h06;
   localparam logic [7:0] OFS_STAT      = 8'h07;

   // reset values and writable bits
   localparam logic [7:0] RST_MASK      = 8'hE0;
   localparam logic [7:0] RST_MODE      = 8'h20;
   localparam logic [7:0] RST_STAT      = 8'h03;
   localparam logic [7:0] WMSK_MASK     = 8'hEF;
   localparam logic [7:0] WMSK_MODE     = 8'hFA;

   // mode byte fields
   localparam int         MODE_OE       = 7;
   localparam int         MODE_FDBL     = 6;
   localparam int         MODE_HICCUP   = 5;
   localparam int         MODE_SDRAIN   = 4;
   localparam int         MODE_FDRAIN   = 3;
   localparam int         MODE_LIGHT_LOAD_FORCED_PWM     = 1;

   // status byte and mask fields
   localparam int         FLAG_HI       = 7;
   localparam int         FLAG_LO       = 5;
   localparam int         RPT_HI        = 1;
   localparam int         RPT_LO        = 0;
   localparam logic [2:0] STAT_RSVD     = 3'h0;

   // conversion mode report codes
   localparam logic [1:0] CMODE_BOOST   = 2'h0;
   localparam logic [1:0] CMODE_BUCK    = 2'h1;
   localparam logic [1:0] CMODE_MIXED   = 2'h2;
   localparam logic [1:0] CMODE_RSVD    = 2'h3;

   // serial port
   localparam logic [3:0] BYTE_BITS     = 4'h8;
   localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;  // arbitrary value

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_AACK = 4'b0010,
      ST_PTR  = 4'b0011,
      ST_PACK = 4'b0100,
      ST_WDAT = 4'b0101,
      ST_WACK = 4'b0110,
      ST_RDAT = 4'b0111,
      ST_RACK = 4'b1000
   } cmsr_state_t;

   typedef struct packed {
      cmsr_state_t st;
      logic [3:0]  cnt;
      logic [7:0]  sh;
      logic [7:0]  ptr;
      logic        rd;
      logic        sda_drv;
      logic        scl_p;
      logic        sda_p;
      logic [7:0]  mode;
      logic [7:0]  mask;
   } cmsr_regs_t;

endpackage

// ### verilog/cmsr_regs.sv
// mode, mask and status registers behind a two-wire serial slave port
// assumes scl/sda and fault/mode levels arrive asynchronously from pins
`timescale 1ns/10ps
module cmsr_regs #(
   parameter logic [6:0] DEV_ADDR = cmsr_pkg::DEV_ADDR_DFLT
) (
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       srst_i,
   // serial port, sda open drain
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   // power stage events and state
   input  wire logic       short_fault_i,
   input  wire logic       overcurrent_i,
   input  wire logic       overvoltage_i,
   input  wire logic [1:0] conv_mode_i,
   // power stage controls
   output logic            out_enable_o,
   output logic            freq_double_active_o,
   output logic            hiccup_enable_o,
   output logic            drain_sink_on_o,
   output logic            light_load_forced_pwm_o,
   // alert pin, open drain
   output logic            fault_alert_pin_o,
   output logic            fault_alert_pin_oe_n_o
);
   import cmsr_pkg::*;

   cmsr_regs_t q;
   cmsr_regs_t d;

   logic       scl_s;
   logic       sda_s;
   logic [2:0] fault_s;
   logic [1:0] cmode_s;
   logic [2:0] flags;
   logic [7:0] status;
   logic       stat_rd;

   // pins, idle-high lines and an unknown mode come out of reset
   cmsr_sync #(
      .W       (7),
      .RST_VAL (7'h63)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .async_i   ({scl_i, sda_i, short_fault_i, overcurrent_i,
                   overvoltage_i, conv_mode_i}),
      .sync_o    ({scl_s, sda_s, fault_s, cmode_s})
   );

   cmsr_flag_latch #(
      .W (3)
   ) u_flags (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .set_i     (fault_s),
      .clr_i     (stat_rd),
      .flag_o    (flags)
   );

   // mode report follows the stage; reserved bits fixed at zero
   assign status = {flags, STAT_RSVD, cmode_s};

   function automatic logic [7:0] rd_byte(input logic [7:0] ptr,
                                          input logic [7:0] mode,
                                          input logic [7:0] mask,
                                          input logic [7:0] stat);
      logic [7:0] v;
      case (ptr)
         OFS_MASK: v = mask;
         OFS_MODE: v = mode;
         OFS_STAT: v = stat;
         default:  v = 8'h00;
      endcase
      return v;
   endfunction

   // every shift phase ends on the same bit count
   function automatic logic byte_done(input logic [3:0] cnt);
      return (cnt == BYTE_BITS);
   endfunction

   function automatic logic [3:0] cnt_next(input logic [3:0] cnt);
      return cnt + 4'h1;
   endfunction

   // pointer steps after each data byte and wraps at the top
   function automatic logic [7:0] ptr_next(input logic [7:0] ptr);
      return ptr + 8'h01;
   endfunction

   always_comb begin
      logic       rise;
      logic       fall;
      logic       start;
      logic       stop;
      logic       load;
      logic [7:0] byte_v;
      d       = q;
      stat_rd = 1'b0;
      load    = 1'b0;
      byte_v  = 8'h00;
      rise    = scl_s & ~q.scl_p;
      fall    = ~scl_s & q.scl_p;
      start   = scl_s & q.scl_p & q.sda_p & ~sda_s;
      stop    = scl_s & q.scl_p & ~q.sda_p & sda_s;
      d.scl_p = scl_s;
      d.sda_p = sda_s;
      if (start) begin
         d.st      = ST_ADDR;
         d.cnt     = 4'h0;
         d.sda_drv = 1'b0;
      end else if (stop) begin
         d.st      = ST_IDLE;
         d.sda_drv = 1'b0;
      end else if (rise) begin
         case (q.st)
            ST_ADDR, ST_PTR, ST_WDAT: begin
               d.sh  = {q.sh[6:0], sda_s};
               d.cnt = cnt_next(q.cnt);
            end
            ST_RDAT: begin
               d.cnt = cnt_next(q.cnt);
            end
            ST_RACK: begin
               // master nack ends the read burst
               if (sda_s) begin
                  d.st = ST_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (fall) begin
         case (q.st)
            ST_ADDR: begin
               if (byte_done(q.cnt)) begin
                  d.cnt = 4'h0;
                  if (q.sh[7:1] == DEV_ADDR) begin
                     d.sda_drv = 1'b1;
                     d.rd      = q.sh[0];
                     d.st      = ST_AACK;
                  end else begin
                     d.st = ST_IDLE;
                  end
               end
            end
            ST_PTR: begin
               if (byte_done(q.cnt)) begin
                  d.cnt     = 4'h0;
                  d.sda_drv = 1'b1;
                  d.ptr     = q.sh;
                  d.st      = ST_PACK;
               end
            end
            ST_WDAT: begin
               if (byte_done(q.cnt)) begin
                  d.cnt     = 4'h0;
                  d.sda_drv = 1'b1;
                  d.st      = ST_WACK;
                  d.ptr     = ptr_next(q.ptr);
                  // status and unmapped offsets swallow the write
                  if (q.ptr == OFS_MODE) begin
                     d.mode = q.sh & WMSK_MODE;
                  end else if (q.ptr == OFS_MASK) begin
                     d.mask = q.sh & WMSK_MASK;
                  end
               end
            end
            ST_AACK: begin
               if (q.rd) begin
                  load = 1'b1;
               end else begin
                  d.sda_drv = 1'b0;
                  d.st      = ST_PTR;
               end
            end
            ST_PACK, ST_WACK: begin
               d.sda_drv = 1'b0;
               d.st      = ST_WDAT;
            end
            ST_RDAT: begin
               if (byte_done(q.cnt)) begin
                  d.sda_drv = 1'b0;
                  d.cnt     = 4'h0;
                  d.st      = ST_RACK;
               end else begin
                  d.sda_drv = ~q.sh[7];
                  d.sh      = {q.sh[6:0], 1'b0};
               end
            end
            ST_RACK: begin
               load = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // byte is captured before the flags clear, so the host sees them
      if (load) begin
         byte_v    = rd_byte(q.ptr, q.mode, q.mask, status);
         d.sda_drv = ~byte_v[7];
         d.sh      = {byte_v[6:0], 1'b0};
         d.cnt     = 4'h0;
         d.ptr     = ptr_next(q.ptr);
         d.st      = ST_RDAT;
         stat_rd   = (q.ptr == OFS_STAT);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         q.st      <= ST_IDLE;
         q.cnt     <= 4'h0;
         q.sh      <= 8'h00;
         q.ptr     <= 8'h00;
         q.rd      <= 1'b0;
         q.sda_drv <= 1'b0;
         q.scl_p   <= 1'b1;
         q.sda_p   <= 1'b1;
         q.mode    <= RST_MODE;
         q.mask    <= RST_MASK;
      end else begin
         q <= d;
      end
   end

   assign sda_o      = 1'b0;
   assign sda_oe_n_o = ~q.sda_drv;

   assign out_enable_o            = q.mode[MODE_OE];
   // doubling only takes hold while the stage reports buck-boost
   assign freq_double_active_o    = q.mode[MODE_FDBL] &
                                    (cmode_s == CMODE_MIXED);
   assign hiccup_enable_o         = q.mode[MODE_HICCUP];
   // no time limit here; long forced drain at high vout is host's job
   assign drain_sink_on_o         = (q.mode[MODE_SDRAIN] &
                                     ~q.mode[MODE_OE]) |
                                    q.mode[MODE_FDRAIN];
   assign light_load_forced_pwm_o = q.mode[MODE_LIGHT_LOAD_FORCED_PWM];

   assign fault_alert_pin_o       = 1'b0;
   assign fault_alert_pin_oe_n_o  =
      ~|(flags & q.mask[FLAG_HI:FLAG_LO]);
endmodule

// ### verilog/cmsr_sync.sv
// two flip-flop synchroniser for a group of asynchronous levels
// assumes the inputs are steady for several clock periods at a time
`timescale 1ns/10ps
module cmsr_sync #(
   parameter int         W       = 1,
   parameter logic [6:0] RST_VAL = 7'h00
) (
   // clock and reset
   input  wire logic         clk_sys_i,
   input  wire logic         srst_i,
   // levels
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } cmsr_sync_t;

   cmsr_sync_t q;
   cmsr_sync_t d;

   always_comb begin
      d.meta = async_i;
      d.sync = q.meta;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         q.meta <= RST_VAL[W-1:0];
         q.sync <= RST_VAL[W-1:0];
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.sync;
endmodule
